/* hw/serial_register_port.sv */
// Serial register port: pin-side shifters and system-side access strobes.
`timescale 1ns/1ps
module serial_register_port
	import serport_pkg::*;
#(
	parameter logic [serport_pkg::ADDR_W-1:0] CSUM_ADDR = serport_pkg::CHECKSUM_ADDR,
	parameter int SYNC_STAGES = 2
) (
	// System clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// Serial pins
	input  wire logic                       sclk,
	input  wire logic                       csN,
	input  wire logic                       din,
	output logic                            dout,
	output logic                            doutOeN,
	// Register map lookup
	output logic [serport_pkg::ADDR_W-1:0]  accAddr,
	output logic                            accRdStb,
	input  wire logic [serport_pkg::DATA_W-1:0]  accRdData,
	input  wire logic [serport_pkg::WIDTH_W-1:0] accWidth,
	// Register map write bytes
	output logic                            wrStb,
	output serport_pkg::wrbyte_s            wrByte,
	// Read completion and its checksum
	output logic                            rdDone,
	output logic [serport_pkg::CSUM_W-1:0]  lastChecksum
);
	import serport_pkg::*;

	generate
		if (SYNC_STAGES < 2) begin : g_check
			$error("serial_register_port needs two synchroniser stages");
		end
	endgenerate

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	phase_e              phase_r;
	phase_e              phase_nxt;
	logic [CNT_W-1:0]    bitCnt_r;
	logic [CNT_W-1:0]    bitCnt_nxt;
	logic [BYTE_W-2:0]   rxShift_r;
	logic [BYTE_W-2:0]   rxShift_nxt;
	logic [BYTE_W-1:0]   cmd_r;
	logic [BYTE_W-1:0]   cmd_nxt;
	logic [LANE_W-1:0]   bytesDone_r;
	logic [LANE_W-1:0]   bytesDone_nxt;
	logic                cmdTgl_r;
	logic                cmdTgl_nxt;
	logic                wrTgl_r;
	logic                wrTgl_nxt;
	logic                doneTgl_r;
	logic                doneTgl_nxt;
	wrbyte_s             wrHold_r;
	wrbyte_s             wrHold_nxt;
	logic [DATA_W-1:0]   txShift_r;
	logic [DATA_W-1:0]   txShift_nxt;
	logic                txActive_r;
	logic                txActive_nxt;
	logic [CSUM_W-1:0]   checksum_r;
	logic [CSUM_W-1:0]   checksum_nxt;
	logic [ADDR_W-1:0]   accAddr_r;
	logic [ADDR_W-1:0]   accAddr_nxt;
	logic                accRdStb_r;
	logic                accRdStb_nxt;
	logic                snapLoad_r;
	logic                snapLoad_nxt;
	snap_s               snap_r;
	snap_s               snap_nxt;
	logic                wrStb_r;
	logic                wrStb_nxt;
	wrbyte_s             wrByte_r;
	wrbyte_s             wrByte_nxt;
	logic                rdDone_r;
	logic                rdDone_nxt;
	logic [CSUM_W-1:0]   lastCsum_r;
	logic [CSUM_W-1:0]   lastCsum_nxt;
	logic                serRst;
	logic [BYTE_W-1:0]   rxByte;
	logic                byteDone;
	logic                lastByte;
	logic                isCsum;
	logic [LANE_W-1:0]   xferBytes;
	logic [LANE_W-1:0]   padBytes;
	logic [DATA_W-1:0]   loadVal;
	logic [DATA_W-1:0]   loadAligned;
	logic                cmdPulse;
	logic                wrPulse;
	logic                donePulse;
	logic [LANE_W-1:0]   decBytes;
	logic [BYTE_W-1:0]   decHeadMask;
	logic [DATA_W-1:0]   decDataMask;

	// -----------------------------------------------------------------
	// Pin-side reset and shared decodes
	// -----------------------------------------------------------------

	// Chip select high holds the transfer state in reset, so its falling
	// edge always releases the port into command mode.
	assign serRst = rst | csN;

	// The checksum address is served locally and is always one byte long.
	assign isCsum    = (cmd_r[ADDR_W-1:0] == CSUM_ADDR);
	assign xferBytes = isCsum ? CSUM_BYTES : snap_r.bytes;
	assign rxByte    = {rxShift_r, din};
	assign byteDone  = (bitCnt_r == LAST_BIT);
	assign lastByte  = (bytesDone_r == LANE_W'(xferBytes - 2'h1));

	// -----------------------------------------------------------------
	// Falling-edge transfer sequencer
	// -----------------------------------------------------------------

	// Every falling edge takes one input bit and advances the bit count.
	always_comb begin
		phase_nxt     = phase_r;
		bitCnt_nxt    = bitCnt_r + CNT_W'(1);
		rxShift_nxt   = rxByte[BYTE_W-2:0];
		cmd_nxt       = cmd_r;
		bytesDone_nxt = bytesDone_r;
		unique case (phase_r)
			PH_CMD: begin
				if (byteDone) begin
					cmd_nxt       = rxByte;
					bytesDone_nxt = '0;
					if (rxByte[CMD_WRITE_BIT]) begin
						phase_nxt = PH_WRITE;
					end else begin
						phase_nxt = PH_READ;
					end
				end
			end
			PH_WRITE, PH_READ: begin
				if (byteDone) begin
					if (lastByte) begin
						phase_nxt = PH_CMD;
					end else begin
						bytesDone_nxt = bytesDone_r + LANE_W'(1);
					end
				end
			end
			default: begin
				phase_nxt = PH_CMD;
			end
		endcase
	end

	// Power-on or pin reset and chip select both land here in command mode.
	always_ff @(negedge sclk or posedge serRst) begin
		if (serRst) begin
			phase_r     <= PH_CMD;
			bitCnt_r    <= '0;
			rxShift_r   <= '0;
			cmd_r       <= '0;
			bytesDone_r <= '0;
		end else begin
			phase_r     <= phase_nxt;
			bitCnt_r    <= bitCnt_nxt;
			rxShift_r   <= rxShift_nxt;
			cmd_r       <= cmd_nxt;
			bytesDone_r <= bytesDone_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Falling-edge event toggles and write byte hold
	// -----------------------------------------------------------------

	// Only a byte whose eighth bit arrived raises a write event, so a byte
	// cut short by chip select is dropped. The hold register then stays
	// put for the gap the host leaves between bytes.
	always_comb begin
		cmdTgl_nxt  = cmdTgl_r;
		wrTgl_nxt   = wrTgl_r;
		doneTgl_nxt = doneTgl_r;
		wrHold_nxt  = wrHold_r;
		if (byteDone && phase_r == PH_CMD) begin
			cmdTgl_nxt = ~cmdTgl_r;
		end
		if (byteDone && phase_r == PH_WRITE && !isCsum) begin
			wrTgl_nxt       = ~wrTgl_r;
			wrHold_nxt.addr = cmd_r[ADDR_W-1:0];
			wrHold_nxt.lane = LANE_W'(xferBytes - 2'h1 - bytesDone_r);
			if (bytesDone_r == '0) begin
				wrHold_nxt.data = rxByte & snap_r.headMask;
			end else begin
				wrHold_nxt.data = rxByte;
			end
		end
		if (byteDone && lastByte && phase_r == PH_READ) begin
			doneTgl_nxt = ~doneTgl_r;
		end
	end

	// These must not see chip select, or a rising select would fake events.
	always_ff @(negedge sclk or posedge rst) begin
		if (rst) begin
			cmdTgl_r  <= 1'b0;
			wrTgl_r   <= 1'b0;
			doneTgl_r <= 1'b0;
			wrHold_r  <= '0;
		end else begin
			cmdTgl_r  <= cmdTgl_nxt;
			wrTgl_r   <= wrTgl_nxt;
			doneTgl_r <= doneTgl_nxt;
			wrHold_r  <= wrHold_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Rising-edge read shifter
	// -----------------------------------------------------------------

	// The snapshot or the checksum is right justified, so it is moved up
	// until its first byte sits in the top lane of the shifter.
	always_comb begin
		padBytes    = LANE_W'(FULL_BYTES - xferBytes);
		loadVal     = isCsum ? DATA_W'(checksum_r) : snap_r.data;
		loadAligned = loadVal << {padBytes, 3'h0};
	end

	// The first rising edge of a read loads the whole value at once, later
	// ones shift it; any other phase disarms the shifter.
	always_comb begin
		txShift_nxt  = txShift_r;
		txActive_nxt = txActive_r;
		if (phase_r == PH_READ) begin
			if (!txActive_r) begin
				txShift_nxt  = loadAligned;
				txActive_nxt = 1'b1;
			end else begin
				txShift_nxt = txShift_r << 1;
			end
		end else begin
			txActive_nxt = 1'b0;
		end
	end

	always_ff @(posedge sclk or posedge serRst) begin
		if (serRst) begin
			txShift_r  <= '0;
			txActive_r <= 1'b0;
		end else begin
			txShift_r  <= txShift_nxt;
			txActive_r <= txActive_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Read checksum
	// -----------------------------------------------------------------

	// Counts the ones on the output line; the count restarts with the bit
	// that opens a read, so it equals the ones of the last read.
	always_comb begin
		checksum_nxt = checksum_r;
		if (phase_r == PH_READ) begin
			if (!txActive_r) begin
				checksum_nxt = CSUM_RESET + CSUM_W'(loadAligned[DATA_W-1]);
			end else begin
				checksum_nxt = checksum_r + CSUM_W'(txShift_nxt[DATA_W-1]);
			end
		end
	end

	// Survives chip select, so the host can read it in a later transfer.
	always_ff @(posedge sclk or posedge rst) begin
		if (rst) begin
			checksum_r <= CSUM_RESET;
		end else begin
			checksum_r <= checksum_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Serial output drive
	// -----------------------------------------------------------------

	// The enable falls away when the last falling edge ends the read, and
	// at once when chip select rises because both terms reset then.
	assign doutOeN = ~(txActive_r && phase_r == PH_READ);
	assign dout    = txShift_r[DATA_W-1];

	// -----------------------------------------------------------------
	// Crossing into the system clock
	// -----------------------------------------------------------------

	toggle_sync #(
		.STAGES (SYNC_STAGES)
	) u_cmdSync (
		.clk   (clk),
		.rst   (rst),
		.tglIn (cmdTgl_r),
		.pulse (cmdPulse)
	);

	toggle_sync #(
		.STAGES (SYNC_STAGES)
	) u_wrSync (
		.clk   (clk),
		.rst   (rst),
		.tglIn (wrTgl_r),
		.pulse (wrPulse)
	);

	toggle_sync #(
		.STAGES (SYNC_STAGES)
	) u_doneSync (
		.clk   (clk),
		.rst   (rst),
		.tglIn (doneTgl_r),
		.pulse (donePulse)
	);

	width_decode u_widthDec (
		.width    (accWidth),
		.bytes    (decBytes),
		.headMask (decHeadMask),
		.dataMask (decDataMask)
	);

	// -----------------------------------------------------------------
	// System-side access sequencing
	// -----------------------------------------------------------------

	// The pin side changes cmd_r, wrHold_r and checksum_r only before the
	// toggle that announces them, so they are stable when read here. The
	// snapshot goes the other way and is ready about four system cycles
	// after the command, well inside the half serial period it waits.
	always_comb begin
		accAddr_nxt  = accAddr_r;
		accRdStb_nxt = 1'b0;
		snapLoad_nxt = cmdPulse;
		snap_nxt     = snap_r;
		wrStb_nxt    = 1'b0;
		wrByte_nxt   = wrByte_r;
		rdDone_nxt   = 1'b0;
		lastCsum_nxt = lastCsum_r;
		if (cmdPulse) begin
			accAddr_nxt  = cmd_r[ADDR_W-1:0];
			accRdStb_nxt = ~cmd_r[CMD_WRITE_BIT];
		end
		if (snapLoad_r) begin
			snap_nxt.data     = accRdData & decDataMask;
			snap_nxt.bytes    = decBytes;
			snap_nxt.headMask = decHeadMask;
		end
		if (wrPulse) begin
			wrStb_nxt  = 1'b1;
			wrByte_nxt = wrHold_r;
		end
		if (donePulse) begin
			rdDone_nxt   = 1'b1;
			lastCsum_nxt = checksum_r;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			accAddr_r  <= '0;
			accRdStb_r <= 1'b0;
			snapLoad_r <= 1'b0;
			snap_r     <= '0;
			wrStb_r    <= 1'b0;
			wrByte_r   <= '0;
			rdDone_r   <= 1'b0;
			lastCsum_r <= CSUM_RESET;
		end else begin
			accAddr_r  <= accAddr_nxt;
			accRdStb_r <= accRdStb_nxt;
			snapLoad_r <= snapLoad_nxt;
			snap_r     <= snap_nxt;
			wrStb_r    <= wrStb_nxt;
			wrByte_r   <= wrByte_nxt;
			rdDone_r   <= rdDone_nxt;
			lastCsum_r <= lastCsum_nxt;
		end
	end

	// -----------------------------------------------------------------
	// Outputs
	// -----------------------------------------------------------------
	assign accAddr      = accAddr_r;
	assign accRdStb     = accRdStb_r;
	assign wrStb        = wrStb_r;
	assign wrByte       = wrByte_r;
	assign rdDone       = rdDone_r;
	assign lastChecksum = lastCsum_r;
endmodule

/* hw/serport_pkg.sv */
// Constants, types and layouts shared by the serial register port.
// Summary of operation
// - Clear the 6-bit checksum before the first read bit goes out.
// - Add every read bit driven on a rising edge into the checksum.
// - Reading the checksum register yields a new checksum of that read.
// - After reset and chip-select fall, the next byte is a command.
// - Command byte is 8 bits; MSB one means write, zero means read.
// - Six low command bits give the register address.
// - After the last register bit moves, return to command mode.
// - Sample the serial input on each falling serial clock edge.
// - Change the serial output on each rising serial clock edge.
// - A chip-select fall resets the port into command mode.
// - Chip select high mid-transfer aborts it and floats the output.
// - A partly shifted write byte is never committed.
// - Registers span up to 3 bytes; first byte lands as MSB.
// - Write data is right justified; excess top bits are dropped.
// - Read data starts on the next rising edge, one bit per edge.
// - Output floats at the falling edge of the last read pulse.
// - An aborted read floats the output when chip select rises.
// - A read captures the whole register value at its start.
package serport_pkg;

	// -----------------------------------------------------------------
	// Widths and fixed values
	// -----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 24;
	localparam int BYTE_W = 8;
	localparam int MAX_BYTES = 3;
	localparam int CSUM_W = 6;
	localparam int WIDTH_W = 5;
	localparam int CNT_W = 3;
	localparam int LANE_W = 2;
	localparam int CMD_WRITE_BIT = 7;
	localparam logic [ADDR_W-1:0] CHECKSUM_ADDR = 6'h3E;
	localparam logic [CSUM_W-1:0] CSUM_RESET = 6'h00;
	localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;
	localparam logic [LANE_W-1:0] CSUM_BYTES = 2'h1;
	localparam logic [LANE_W-1:0] FULL_BYTES = 2'h3;
	localparam logic [WIDTH_W-1:0] FULL_WIDTH = 5'h18;
	localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hFF;

	// -----------------------------------------------------------------
	// Host timing, kept for reference by the system side
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int WRITE_BYTE_GAP_US = 4;
	localparam int WRITE_TO_READ_GAP_US = 4;
	localparam int WRITE_BYTE_GAP_CYC =
		(WRITE_BYTE_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_TO_READ_GAP_CYC =
		(WRITE_TO_READ_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// -----------------------------------------------------------------
	// Types
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {PH_CMD, PH_WRITE, PH_READ} phase_e;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic [LANE_W-1:0] bytes;
		logic [BYTE_W-1:0] headMask;
	} snap_s;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [LANE_W-1:0] lane;
		logic [BYTE_W-1:0] data;
	} wrbyte_s;

endpackage

/* hw/toggle_sync.sv */
// Toggle-to-pulse event synchroniser into the system clock domain.
`timescale 1ns/1ps
module toggle_sync #(
	parameter int STAGES = 2
) (
	// System clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Toggle from the other domain and the resulting pulse
	input  wire logic tglIn,
	output logic      pulse
);
	generate
		if (STAGES < 2) begin : g_check
			$error("toggle_sync needs at least two stages");
		end
	endgenerate

	logic [STAGES:0] sync_r;
	logic [STAGES:0] sync_nxt;

	// Only the last two taps feed the edge detector, never the first.
	always_comb begin
		sync_nxt = {sync_r[STAGES-1:0], tglIn};
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sync_r <= '0;
		end else begin
			sync_r <= sync_nxt;
		end
	end

	assign pulse = sync_r[STAGES] ^ sync_r[STAGES-1];
endmodule

/* hw/width_decode.sv */
// Maps a register width in bits to byte count and justification masks.
`timescale 1ns/1ps
module width_decode
	import serport_pkg::*;
(
	// Width of the addressed register in bits
	input  wire logic [serport_pkg::WIDTH_W-1:0] width,
	// Derived transfer length and masks
	output logic [serport_pkg::LANE_W-1:0]  bytes,
	output logic [serport_pkg::BYTE_W-1:0]  headMask,
	output logic [serport_pkg::DATA_W-1:0]  dataMask
);
	import serport_pkg::*;

	logic [WIDTH_W-1:0] wClamp;
	logic [WIDTH_W:0]   wRound;
	logic [WIDTH_W-1:0] headBits;

	// Zero and oversize widths clamp so the masks never wrap.
	always_comb begin
		wClamp = width;
		if (width > FULL_WIDTH) begin
			wClamp = FULL_WIDTH;
		end else if (width == '0) begin
			wClamp = WIDTH_W'(1);
		end
		wRound = {1'b0, wClamp} + (WIDTH_W+1)'(BYTE_W - 1);
		bytes = wRound[LANE_W+2:3];
		headBits = wClamp - WIDTH_W'({bytes - 2'h1, 3'h0});
		headMask = BYTE_ONES >> (BYTE_W - int'(headBits));
		dataMask = {DATA_W{1'b1}} >> (DATA_W - int'(wClamp));
	end
endmodule

/* test/host_model.sv */
// Host model: drives serial clock, select and data, reads the output.
`timescale 1ns/1ps
module host_model (
	// Pins driven by the host
	output logic sclk,
	output logic csN,
	output logic din,
	// Output from the port
	input  logic dout,
	input  logic doutOeN
);
	logic lastV;
	logic line;

	// A floating line shows the inverse of its last value, never a kept level.
	always @(dout or doutOeN) begin
		if (!doutOeN) begin
			lastV = dout;
		end
	end
	assign line = doutOeN ? ~lastV : dout;

	// The clock idles high and stands still outside frames.
	initial begin
		sclk = 1'b1;
		csN = 1'b1;
		din = 1'b0;
		lastV = 1'b0;
	end

	// Select is held low over a whole transfer.
	task automatic sel();
		#16 csN = 1'b0;
		#16;
	endtask
	task automatic desel();
		#16 csN = 1'b1;
		din = ~din;
		#16;
	endtask

	// Shift n bits MSB first; the output is read just before each fall.
	task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - n; i--) begin
			din = tx[i];
			#16;
			rx[i] = line;
			sclk = 1'b0;
			#32 sclk = 1'b1;
			#16;
		end
	endtask
endmodule

/* test/serial_register_port_properties.sv */
// Concurrent checks on the serial register port pins and strobes.
`timescale 1ns/1ps
module serial_register_port_properties
	import serport_pkg::*;
#(
	parameter logic [serport_pkg::ADDR_W-1:0] CSUM_ADDR = serport_pkg::CHECKSUM_ADDR
) (
	// System clock and reset
	input logic                               clk,
	input logic                               rst,
	// Serial pins
	input logic                               sclk,
	input logic                               csN,
	input logic                               din,
	input logic                               dout,
	input logic                               doutOeN,
	// Register map side
	input logic [serport_pkg::ADDR_W-1:0]     accAddr,
	input logic                               accRdStb,
	input logic [serport_pkg::DATA_W-1:0]     accRdData,
	input logic [serport_pkg::WIDTH_W-1:0]    accWidth,
	input logic                               wrStb,
	input serport_pkg::wrbyte_s               wrByte,
	input logic                               rdDone,
	input logic [serport_pkg::CSUM_W-1:0]     lastChecksum
);
	import serport_pkg::*;

	// ----
	// Pin timing, sampled by the fast system clock.
	// ----
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_wrPulse;
		wrStb ##1 !wrStb;
	endsequence
	sequence s_addrHeld;
		$stable(accAddr) [*8];
	endsequence
	property p_oe_cs;
		csN && $past(csN) |-> doutOeN;
	endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("output driven while deselected");
	property p_dout_rise;
		!doutOeN && $changed(dout) |-> $rose(sclk);
	endproperty
	a_dout_rise: assert property (p_dout_rise) else $error("output moved off a rising edge");
	property p_oe_on;
		$fell(doutOeN) |-> $rose(sclk);
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("output enabled off a rising edge");
	property p_oe_off;
		$rose(doutOeN) |-> $fell(sclk) || $rose(csN);
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("output floated at a wrong moment");
	// ----
	// System side strobes.
	// ----
	property p_wr_addr;
		wrStb |-> wrByte.addr == accAddr && wrByte.addr != CSUM_ADDR;
	endproperty
	a_wr_addr: assert property (p_wr_addr) else $error("write byte has a wrong address");
	property p_wr_lane;
		wrStb |-> wrByte.lane < 2'h3;
	endproperty
	a_wr_lane: assert property (p_wr_lane) else $error("write lane beyond three bytes");
	property p_wr_pulse;
		$rose(wrStb) |-> s_wrPulse;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe not one cycle");
	property p_wr_hold;
		!wrStb |-> $stable(wrByte);
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write byte moved without strobe");
	property p_sum_hold;
		!rdDone |-> $stable(lastChecksum);
	endproperty
	a_sum_hold: assert property (p_sum_hold) else $error("checksum moved without a read");
	property p_sum_max;
		rdDone |-> lastChecksum <= 6'h18;
	endproperty
	a_sum_max: assert property (p_sum_max) else $error("checksum above bit count");
	property p_rd_addr;
		accRdStb |=> s_addrHeld;
	endproperty
	a_rd_addr: assert property (p_rd_addr) else $error("address moved during a read");
endmodule

bind serial_register_port serial_register_port_properties #(.CSUM_ADDR(CSUM_ADDR)) props_i (
	.clk, .rst, .sclk, .csN, .din, .dout, .doutOeN, .accAddr, .accRdStb,
	.accRdData, .accWidth, .wrStb, .wrByte, .rdDone, .lastChecksum
);

/* test/test_serial_register_port.sv */
// Self-checking bench for the serial register port.
`timescale 1ns/1ps
module test_serial_register_port;
	import serport_pkg::*;
	localparam int TMO = 20000;
	logic                  clk;
	logic                  rst;
	logic                  sclk;
	logic                  csN;
	logic                  din;
	logic                  dout;
	logic                  doutOeN;
	logic [ADDR_W-1:0]     accAddr;
	logic                  accRdStb;
	logic [DATA_W-1:0]     accRdData;
	logic [WIDTH_W-1:0]    accWidth;
	logic                  wrStb;
	wrbyte_s               wrByte;
	logic                  rdDone;
	logic [CSUM_W-1:0]     lastChecksum;
	logic [DATA_W-1:0]     regMem [64];
	logic [WIDTH_W-1:0]    regW [64];
	wrbyte_s               wrQ [$];
	int                    errorCnt;
	int                    checkCount;
	int                    cycles;
	int                    rdStbCnt = 0;
	int                    rdDoneCnt = 0;
	logic [7:0]            rx;
	logic [23:0]           v;

	serial_register_port serial_register_port_i (
		.clk, .rst, .sclk, .csN, .din, .dout, .doutOeN, .accAddr, .accRdStb,
		.accRdData, .accWidth, .wrStb, .wrByte, .rdDone, .lastChecksum
	);
	host_model host_model_i (.sclk, .csN, .din, .dout, .doutOeN);

	// Register map stand-in: a plain lookup by the last command address.
	assign accRdData = regMem[accAddr];
	assign accWidth = regW[accAddr];

	// Strobes are looked at on the falling clock, where they have settled.
	always @(negedge clk) begin
		if (wrStb === 1'b1) begin
			wrQ.push_back(wrByte);
		end
		if (accRdStb === 1'b1) begin
			rdStbCnt++;
		end
		if (rdDone === 1'b1) begin
			rdDoneCnt++;
		end
	end

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// A hung handshake ends the run as a failure.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == TMO) begin
			errorCnt++;
			finalReport();
		end
	end

	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		checkCount++;
		if (exp !== got) begin
			errorCnt++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic finalReport();
		if (errorCnt == 0 && checkCount > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		rst = 1'b1;
		errorCnt = 0;
		checkCount = 0;
		cycles = 0;
		for (int i = 0; i < 64; i++) begin
			regMem[i] = 24'h000000;
			regW[i] = 5'h08;
		end
		regMem[5] = 24'hA5C3F1;
		regW[5] = 5'h18;
		regW[10] = 5'h0C;
		regW[17] = 5'h10;
		regMem[15] = 24'h00002D;
		regW[15] = 5'h06;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		settle(1);
		chk("idleOe", 24'h1, doutOeN);
		// A full-width read; the source changes after the first byte.
		host_model_i.sel();
		host_model_i.shift(8'h05, 8, rx);
		host_model_i.shift(8'h00, 8, v[23:16]);
		@(posedge clk) regMem[5] <= 24'h000000;
		#1;
		host_model_i.shift(8'h00, 8, v[15:8]);
		host_model_i.shift(8'h00, 8, v[7:0]);
		chk("read24", 24'hA5C3F1, v);
		settle(4);
		chk("sum24", 24'h0D, lastChecksum);
		// The checksum read follows at once under the same select.
		host_model_i.shift(8'h3E, 8, rx);
		host_model_i.shift(8'h00, 8, rx);
		chk("sumRead", 24'h0D, rx);
		host_model_i.desel();
		settle(6);
		chk("sumOfSum", 24'h03, lastChecksum);
		// A 12-bit write; excess top bits of the first byte are dropped.
		host_model_i.sel();
		host_model_i.shift(8'h8A, 8, rx);
		host_model_i.shift(8'hFA, 8, rx);
		#4000;
		host_model_i.shift(8'hBC, 8, rx);
		host_model_i.desel();
		#4000;
		settle(1);
		chk("wrCount", 24'h2, wrQ.size());
		chk("wrHigh", 24'h290A, 24'(wrQ[0]));
		chk("wrLow", 24'h28BC, 24'(wrQ[1]));
		// A cut write byte and a checksum write must both be dropped.
		host_model_i.sel();
		host_model_i.shift(8'h91, 8, rx);
		host_model_i.shift(8'h55, 4, rx);
		host_model_i.desel();
		host_model_i.sel();
		host_model_i.shift(8'hBE, 8, rx);
		host_model_i.shift(8'hFF, 8, rx);
		host_model_i.desel();
		settle(20);
		chk("wrDropped", 24'h2, wrQ.size());
		// The host keeps the write-to-read gap even after a dropped write.
		#4000;
		// An aborted read floats the line; a new select starts afresh.
		host_model_i.sel();
		host_model_i.shift(8'h0F, 8, rx);
		host_model_i.shift(8'h00, 4, rx);
		chk("oeMidRead", 24'h0, doutOeN);
		host_model_i.desel();
		chk("oeAbort", 24'h1, doutOeN);
		host_model_i.sel();
		host_model_i.shift(8'h0F, 8, rx);
		host_model_i.shift(8'h00, 8, rx);
		chk("oeLastFall", 24'h1, doutOeN);
		host_model_i.desel();
		chk("read6", 24'h2D, rx);
		settle(4);
		chk("sum6", 24'h04, lastChecksum);
		chk("addr", 24'h0F, accAddr);
		chk("rdStbCount", 24'h4, rdStbCnt);
		chk("rdDoneCount", 24'h3, rdDoneCnt);
		finalReport();
	end
endmodule
